/* File: design/sfdl_pkg.sv */
// Constants for the switch fault diagnosis latches
// Notes on behaviour
// - Configuration write with bit 0 clears thermal latches
// - Error flag is over-temperature OR over-load
// - Over-load monitor is latched into sticky flag
// - Diagnosis frame clears over-load flags at second edge
// - Thermal latch holds channel off until cleared
// - Error copy held clear until third edge
// - First diagnosis after clear still shows old error
// - Persistent over-load sets the flag again immediately
// - Thermal flag latches always; only clear command resets
// - Fault conditions while on report error one
// - Bypass monitor reports comparator of selected channel
// - Serial interface selects or disables sense channel
// - Dynamic shutdown flag clears on read, sets again
// - Channel-on bits switch channels, gated by shutdown latches
package sfdl_pkg;
  localparam int NCH = 5;
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] FRAME_LEN = 4'h8;
  // Frame layout, most significant bit first
  localparam int BIT_WRITE = 7;
  localparam int BIT_RDBK_SEL = 6;
  localparam int ADDR_HI = 5;
  localparam int ADDR_LO = 4;
  localparam int CLR_THERM_BIT = 0;
  localparam int RST_BIT = 1;
  localparam int PWM_BIT = 3;
  localparam int MUX_HI = 2;
  localparam logic [1:0] ADDR_PCR = 2'h1;
  localparam logic [1:0] ADDR_HW_CFG = 2'h2;
  localparam logic [1:0] ADDR_DIAG_CTRL = 2'h3;
  // Reset values
  localparam logic [NCH-1:0] OUT_RST = 5'h00;
  localparam logic PWM_RST = 1'b0;
  localparam logic [2:0] MUX_RST = 3'h6;
  // Mux codes at or above this value disable the sense output
  localparam logic [2:0] MUX_FIRST_OFF = 3'h5;
  // Rising-edge counts (before increment) for the in-frame actions
  localparam logic [3:0] OL_CLR_CNT = 4'h1;
  localparam logic [3:0] OT_ARM_CNT = 4'h2;
  localparam logic [3:0] CNT_MAX = 4'hf;
  // Answer words
  localparam logic [2:0] DIAG_HEAD = 3'h0;
  localparam logic RDBK_MARK = 1'b1;
endpackage

/* File: design/sfdl_core.sv */
// Fault latches, diagnosis word and control registers behind the serial port
module sfdl_core (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic [sfdl_pkg::NCH-1:0] i_overtemp,
  input wire logic [sfdl_pkg::NCH-1:0] i_overload_mon,
  input wire logic [sfdl_pkg::NCH-1:0] i_dyn_shutdown,
  input wire logic [sfdl_pkg::NCH-1:0] i_bypass_cmp,
  input wire logic [sfdl_pkg::NCH-1:0] i_chan_input,
  output logic [sfdl_pkg::NCH-1:0] o_gate_on,
  output logic [sfdl_pkg::NCH-1:0] o_channel_error_flag,
  output logic [sfdl_pkg::NCH-1:0] o_thermal_latch,
  output logic [2:0] o_sense_select,
  output logic o_sense_enable
);
  localparam int N = sfdl_pkg::NCH;
  localparam int SW = 3 + 5 * N;
  // Idle levels: clock low, select high, so reset leaves no false edge
  localparam logic [SW-1:0] SYNC_IDLE = {2'b01, {(SW - 2){1'b0}}};

  // Two-flop synchronisers for every asynchronous input
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= {i_sclk, i_cs_n, i_si, i_overtemp, i_overload_mon, i_dyn_shutdown,
                i_bypass_cmp, i_chan_input};
      sync2 <= sync1;
    end
  end

  wire sclk_s = sync2[SW-1];
  wire cs_n_s = sync2[SW-2];
  wire si_s = sync2[SW-3];
  wire [N-1:0] ot_s = sync2[5*N-1:4*N];
  wire [N-1:0] ol_s = sync2[4*N-1:3*N];
  wire [N-1:0] dyn_s = sync2[3*N-1:2*N];
  wire [N-1:0] byp_s = sync2[2*N-1:N];
  wire [N-1:0] in_s = sync2[N-1:0];

  // Edge detection on the synchronised serial clock and select
  logic sclk_d;
  logic cs_n_d;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  wire frame_start = cs_n_d & ~cs_n_s;
  wire frame_end = ~cs_n_d & cs_n_s;
  wire sclk_rise = ~sclk_d & sclk_s & ~cs_n_s;
  wire sclk_fall = sclk_d & ~sclk_s & ~cs_n_s;

  // Frame shifter
  logic [3:0] bit_cnt;
  logic [sfdl_pkg::FRAME_BITS-1:0] rx_sr;
  logic [sfdl_pkg::FRAME_BITS-1:0] tx_sr;
  logic resp_diag;
  logic rd_pend;
  logic rd_sel;
  logic [1:0] rd_addr;

  wire frame_ok = frame_end & (bit_cnt == sfdl_pkg::FRAME_LEN);
  wire is_write = rx_sr[sfdl_pkg::BIT_WRITE];
  wire is_sel = rx_sr[sfdl_pkg::BIT_RDBK_SEL];
  wire [1:0] addr = rx_sr[sfdl_pkg::ADDR_HI:sfdl_pkg::ADDR_LO];
  wire wr_out = frame_ok & is_write & ~is_sel;
  wire wr_pcr = frame_ok & is_write & is_sel & (addr == sfdl_pkg::ADDR_PCR);
  wire wr_hw_cfg = frame_ok & is_write & is_sel & (addr == sfdl_pkg::ADDR_HW_CFG);
  wire wr_diag_ctrl = frame_ok & is_write & is_sel & (addr == sfdl_pkg::ADDR_DIAG_CTRL);
  wire clr_therm_cmd = wr_hw_cfg & rx_sr[sfdl_pkg::CLR_THERM_BIT];
  wire rst_cmd = wr_hw_cfg & rx_sr[sfdl_pkg::RST_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      bit_cnt <= 4'h0;
      rx_sr <= '0;
    end else if (frame_start) begin
      bit_cnt <= 4'h0;
    end else if (sclk_rise) begin
      rx_sr <= {rx_sr[sfdl_pkg::FRAME_BITS-2:0], si_s};
      if (bit_cnt != sfdl_pkg::CNT_MAX) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // A read request is answered in place of the diagnosis word next frame
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      rd_pend <= 1'b0;
      rd_sel <= 1'b0;
      rd_addr <= 2'h0;
    end else if (frame_ok) begin
      rd_pend <= ~is_write;
      rd_sel <= is_sel;
      rd_addr <= addr;
    end
  end

  // Control registers
  logic [N-1:0] out_reg;
  logic pwm_and;
  logic [2:0] mux_sel;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || rst_cmd) begin
      out_reg <= sfdl_pkg::OUT_RST;
      pwm_and <= sfdl_pkg::PWM_RST;
      mux_sel <= sfdl_pkg::MUX_RST;
    end else begin
      if (wr_out) begin
        out_reg <= rx_sr[N-1:0];
      end
      if (wr_pcr) begin
        pwm_and <= rx_sr[sfdl_pkg::PWM_BIT];
      end
      if (wr_diag_ctrl) begin
        mux_sel <= rx_sr[sfdl_pkg::MUX_HI:0];
      end
    end
  end

  // Sense routing and bypass monitor of the selected channel
  wire sense_en = mux_sel < sfdl_pkg::MUX_FIRST_OFF;
  wire [N-1:0] byp_shift = byp_s >> mux_sel;
  wire bypass_monitor_result = sense_en & byp_shift[0];

  // Over-load clear and over-temperature re-arm timing within a frame
  wire ol_clear = sclk_rise & resp_diag & (bit_cnt == sfdl_pkg::OL_CLR_CNT);
  logic clr_therm_armed;
  logic ot_hold;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      clr_therm_armed <= 1'b0;
      ot_hold <= 1'b0;
    end else if (clr_therm_cmd) begin
      clr_therm_armed <= 1'b1;
    end else if (frame_start && clr_therm_armed) begin
      clr_therm_armed <= 1'b0;
      ot_hold <= 1'b1;
    end else if (frame_end || (sclk_rise && bit_cnt == sfdl_pkg::OT_ARM_CNT)) begin
      ot_hold <= 1'b0;
    end
  end

  // Per-channel latches
  logic [N-1:0] therm;
  logic [N-1:0] err_ot;
  logic [N-1:0] err_ol;
  wire [N-1:0] err_all = err_ot | err_ol;
  wire [N-1:0] drive = pwm_and ? (out_reg & in_s) : (out_reg | in_s);

  genvar ch;
  generate
    for (ch = 0; ch < N; ch++) begin : g_ch
      always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
          therm[ch] <= 1'b0;
          err_ot[ch] <= 1'b0;
          err_ol[ch] <= 1'b0;
          o_gate_on[ch] <= 1'b0;
        end else begin
          // Set wins over the clear command
          therm[ch] <= (therm[ch] & ~clr_therm_cmd) | ot_s[ch];
          err_ot[ch] <= ~ot_hold & (err_ot[ch] | therm[ch]);
          err_ol[ch] <= (err_ol[ch] & ~ol_clear) | ol_s[ch] | dyn_s[ch];
          o_gate_on[ch] <= drive[ch] & ~therm[ch] & ~dyn_s[ch];
        end
      end
    end
  endgenerate

  // Answer word loaded at the start of each frame
  logic [sfdl_pkg::FRAME_BITS-1:0] rdbk_word;
  always_comb begin
    rdbk_word = '0;
    rdbk_word[sfdl_pkg::BIT_WRITE] = sfdl_pkg::RDBK_MARK;
    rdbk_word[sfdl_pkg::BIT_RDBK_SEL] = rd_sel;
    if (!rd_sel) begin
      rdbk_word[N-1:0] = out_reg;
    end else begin
      rdbk_word[sfdl_pkg::ADDR_HI:sfdl_pkg::ADDR_LO] = rd_addr;
      if (rd_addr == sfdl_pkg::ADDR_PCR) begin
        rdbk_word[sfdl_pkg::PWM_BIT] = pwm_and;
      end else if (rd_addr == sfdl_pkg::ADDR_DIAG_CTRL) begin
        rdbk_word[sfdl_pkg::PWM_BIT] = bypass_monitor_result;
        rdbk_word[sfdl_pkg::MUX_HI:0] = mux_sel;
      end
    end
  end

  wire [sfdl_pkg::FRAME_BITS-1:0] diag_word = {sfdl_pkg::DIAG_HEAD, err_all};

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      tx_sr <= '0;
      resp_diag <= 1'b0;
    end else if (frame_start) begin
      // Captured before any in-frame clear takes effect
      tx_sr <= rd_pend ? rdbk_word : diag_word;
      resp_diag <= ~rd_pend;
    end else if (sclk_fall) begin
      tx_sr <= {tx_sr[sfdl_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_channel_error_flag <= '0;
      o_thermal_latch <= '0;
      o_sense_select <= sfdl_pkg::MUX_RST;
      o_sense_enable <= 1'b0;
    end else begin
      o_channel_error_flag <= err_all;
      o_thermal_latch <= therm;
      o_sense_select <= mux_sel;
      o_sense_enable <= sense_en;
    end
  end

  assign o_so = tx_sr[sfdl_pkg::FRAME_BITS-1];
  assign o_so_oe = ~cs_n_s;
endmodule

/* File: testbench/sfdl_chk_assertions.sv */
// Port-level checks of the fault latch block
module sfdl_chk (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic [4:0] i_overtemp,
  input wire logic [4:0] i_overload_mon,
  input wire logic [4:0] i_dyn_shutdown,
  input wire logic [4:0] o_gate_on,
  input wire logic [4:0] o_channel_error_flag,
  input wire logic [4:0] o_thermal_latch,
  input wire logic [2:0] o_sense_select,
  input wire logic o_sense_enable
);
  timeunit 1ns / 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  property p_tl_gate; !(o_thermal_latch & $past(o_thermal_latch) & o_gate_on); endproperty
  a_tl_gate: assert property (p_tl_gate) else $error("gate on under latch");
  property p_tl_set; $stable(i_overtemp) [*6] |-> !(i_overtemp & ~o_thermal_latch); endproperty
  a_tl_set: assert property (p_tl_set) else $error("latch not set");
  property p_tl_hold;
    !i_cs_n && !$past(i_cs_n, 6) |-> !($past(o_thermal_latch) & ~o_thermal_latch); endproperty
  a_tl_hold: assert property (p_tl_hold) else $error("latch cleared in frame");
  property p_ol_err; $stable(i_overload_mon | i_dyn_shutdown) [*6]
    |-> !((i_overload_mon | i_dyn_shutdown) & ~o_channel_error_flag); endproperty
  a_ol_err: assert property (p_ol_err) else $error("overload not flagged");
  property p_dyn_gate; $stable(i_dyn_shutdown) [*6] |-> !(i_dyn_shutdown & o_gate_on); endproperty
  a_dyn_gate: assert property (p_dyn_gate) else $error("gate on in shutdown");
  property p_ot_err; (i_cs_n && $stable(o_thermal_latch)) [*6]
    |-> !(o_thermal_latch & ~o_channel_error_flag); endproperty
  a_ot_err: assert property (p_ot_err) else $error("latch not flagged");
  property p_err_fall;
    ($past(o_channel_error_flag) & ~o_channel_error_flag) != 0 |-> !$past(i_cs_n, 2); endproperty
  a_err_fall: assert property (p_err_fall) else $error("flag cleared outside frame");
  property p_mux_en; $stable(o_sense_select)
    |-> o_sense_enable == (o_sense_select < sfdl_pkg::MUX_FIRST_OFF); endproperty
  a_mux_en: assert property (p_mux_en) else $error("sense enable wrong");
  c_tl: cover property ($rose(o_thermal_latch[0]));
  c_err: cover property ($fell(o_channel_error_flag[1]));
  c_dis: cover property ($fell(o_sense_enable));
endmodule

/* File: testbench/sfdl_host.sv */
// Serial host model that clocks eight-bit frames into the block
module sfdl_host (
  output logic o_sclk = 1'b0,
  output logic o_cs_n = 1'b1,
  output logic o_si = 1'b0,
  input wire logic i_so,
  input wire logic i_so_oe
);
  timeunit 1ns / 1ps;
  // Clock idles low between frames; data changes with the falling edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      #80 o_sclk = 1'b1;
      rx[i] = i_so & i_so_oe;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask
endmodule

/* File: testbench/sfdl_tb.sv */
// Self-checking bench for the fault latch block
module tb;
  timeunit 1ns / 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, cs_n, si, so, oe, sen;
  logic [4:0] ot = 5'h00, ol = 5'h00, dy = 5'h00, bp = 5'h00, gate, err, tl;
  logic [2:0] sel;
  logic [4:0] ci = 5'h00;
  int fails = 0, num_checks = 0;
  sfdl_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(oe));
  sfdl_core dut (.i_sys_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(oe), .i_overtemp(ot), .i_overload_mon(ol), .i_dyn_shutdown(dy),
    .i_bypass_cmp(bp), .i_chan_input(ci), .o_gate_on(gate), .o_channel_error_flag(err),
    .o_thermal_latch(tl), .o_sense_select(sel), .o_sense_enable(sen));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic fr(input logic [7:0] tx, input logic [7:0] ex);
    logic [7:0] rx;
    host.xfer(tx, rx);
    step(12);
    chk(16'(rx), 16'(ex));
  endtask
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  initial begin
    repeat (10000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    step(5);
    nrst = 1'b1;
    step(6);
    fr(8'h95, 8'h00);
    ol = 5'h02;
    step(10);
    fr(8'h95, 8'h02);
    ol = 5'h00;
    step(10);
    chk(16'(err), 16'h0002);
    fr(8'h95, 8'h02);
    fr(8'h95, 8'h00);
    dy = 5'h04;
    step(10);
    chk(16'({gate, err}), 16'h0224);
    fr(8'h95, 8'h04);
    dy = 5'h00;
    fr(8'h95, 8'h04);
    fr(8'h95, 8'h00);
    ot = 5'h03;
    step(10);
    ot = 5'h00;
    step(10);
    chk(16'({tl, gate}), 16'h0074);
    fr(8'he0, 8'h03);
    chk(16'(tl), 16'h0003);
    fr(8'he1, 8'h03);
    chk(16'({tl, gate, err}), 16'h02a3);
    fr(8'h95, 8'h03);
    chk(16'(err), 16'h0000);
    bp = 5'h04;
    fr(8'hf2, 8'h00);
    chk(16'({sen, sel}), 16'h000a);
    fr(8'h70, 8'h00);
    fr(8'h00, 8'hfa);
    fr(8'hf5, 8'h95);
    chk(16'({sen, sel}), 16'h0005);
    fr(8'he2, 8'h00);
    chk(16'({sel, gate}), 16'h00c0);
    fr(8'h93, 8'h00);
    ci = 5'h05;
    step(10);
    chk(16'(gate), 16'h0017);
    fr(8'hd8, 8'h00);
    chk(16'(gate), 16'h0001);
    fr(8'h50, 8'h00);
    fr(8'h95, 8'hd8);
    results();
  end
endmodule
bind sfdl_core sfdl_chk u_chk (.i_sys_clk, .i_nrst, .i_cs_n, .i_overtemp, .i_overload_mon,
  .i_dyn_shutdown, .o_gate_on, .o_channel_error_flag, .o_thermal_latch, .o_sense_select,
  .o_sense_enable);
